/* bench/psg_host_model.sv */
// Purpose: host pulse-train source facing the command pulse pins
// Assumes: one command step every two clocks, one quadrature change per clock
// Notes: pins always driven, idle at the inactive level
`timescale 1ns/1ps
`default_nettype none
module psg_host_model (
   input wire logic ref_clk_i,
   output logic pulse_input_a_o,
   output logic pulse_input_b_o
);
   // ---------------------------------------------
   // pin drive
   // ---------------------------------------------
   logic a = 1'b0;
   logic b = 1'b0;
   logic neg = 1'b0;
   // negative logic inverts both pins at the source
   assign pulse_input_a_o = a ^ neg;
   assign pulse_input_b_o = b ^ neg;
   // two=0 pulse plus sign, two=1 separate forward and reverse trains
   task automatic send(input int n, input logic fwd, input logic two);
      @(posedge ref_clk_i);
      b <= two ? 1'b0 : fwd;
      repeat (n) begin
         @(posedge ref_clk_i);
         if (two && !fwd) begin
            b <= 1'b1;
         end else begin
            a <= 1'b1;
         end
         // one clock between edges of one pin, two between its rising edges, keeps the decoder in step
         @(posedge ref_clk_i);
         a <= 1'b0;
         if (two) b <= 1'b0;
      end
   endtask
   // forward quadrature, a leads b: each loop gives two single-pin changes
   task automatic quad(input int n);
      repeat (n) begin
         @(posedge ref_clk_i);
         a <= ~b;
         @(posedge ref_clk_i);
         b <= a;
      end
   endtask
endmodule
`default_nettype wire

/* bench/psg_top_tb_top.sv */
// Purpose: self-checking bench for the settled, cap and gear logic
// Assumes: quiet window shortened to 20 clocks, gear set to 1:1 except the final 3/2 quadrature check
// Notes: lag expectations are tracked by hand after each step
`timescale 1ns/1ps
`default_nettype none
module psg_top_tb_top;
   // ---------------------------------------------
   // stimulus and checks
   // ---------------------------------------------
   localparam int QC = 20;
   typedef struct {logic [7:0] a; logic [31:0] e;} psg_row_t;
   psg_row_t rows [5] = '{'{8'h00, 32'h007d0800}, '{8'h04, 32'h00000001},
      '{8'h08, 32'h0000000a}, '{8'h0c, 32'h00000046}, '{8'h18, 32'h00000000}};
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0, rd = 1'b0, servo = 1'b0, pat1 = 1'b0, home = 1'b0;
   logic stop = 1'b0, cap = 1'b0, frec = 1'b0, enc = 1'b0, edir = 1'b1;
   logic [6:0] tq = 7'h00;
   logic [6:0] tlim;
   logic [31:0] rdata, lag, d;
   logic flag, alarm, pa, pb;
   int fails = 0;
   int check_count = 0;
   initial begin
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   psg_top #(.QUIET_CYCLES(QC)) DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .servo_on_i(servo), .signal_pattern1_i(pat1),
      .home_return_active_i(home), .forced_stop_i(stop), .pulse_input_a_i(pa),
      .pulse_input_b_i(pb), .thrust_cap_request_i(cap), .fault_recover_input_i(frec),
      .enc_step_i(enc), .enc_dir_i(edir), .torque_now_pct_i(tq),
      .position_settled_flag_o(flag), .torque_limit_pct_o(tlim),
      .alarm_reset_pulse_o(alarm), .lag_count_o(lag));
   psg_host_model host (.ref_clk_i(ref_clk_i), .pulse_input_a_o(pa), .pulse_input_b_o(pb));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t word got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t flag got %b exp %b", $time, g, e);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk_i);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge ref_clk_i);
      wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe edge
   task automatic rd_reg(input logic [7:0] a);
      @(posedge ref_clk_i);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic print_verdict();
      if (fails == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // whole run is well under a thousand clocks
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      fails++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         rd_reg(rows[i].a);
         chk(d, rows[i].e);
      end
      wr_reg(8'h00, 32'h0);
      rd_reg(8'h00);
      chk(d, 32'h00010001);
      tick(QC + 5);
      @(posedge ref_clk_i) servo <= 1'b1;
      tick(1);
      chk_bit(flag, 1'b1);
      host.send(5, 1'b1, 1'b0);
      tick(4);
      chk(lag, 32'h5);
      chk_bit(flag, 1'b0);
      tick(QC);
      chk_bit(flag, 1'b1);
      host.send(12, 1'b1, 1'b0);
      tick(QC + 4);
      chk_bit(flag, 1'b0);
      repeat (7) begin
         @(posedge ref_clk_i) enc <= 1'b1;
         @(posedge ref_clk_i) enc <= 1'b0;
      end
      tick(3);
      chk_bit(flag, 1'b1);
      rd_reg(8'h14);
      chk(d, 32'h0000000a);
      host.send(12, 1'b0, 1'b0);
      tick(4);
      chk(lag, 32'hfffffffe);
      wr_reg(8'h04, 32'h6);
      host.neg <= 1'b1;
      host.send(4, 1'b1, 1'b1);
      host.send(1, 1'b0, 1'b1);
      tick(4);
      chk(lag, 32'h1);
      wr_reg(8'h0c, 32'h7f);
      rd_reg(8'h0c);
      chk(d, 32'h46);
      @(posedge ref_clk_i) cap <= 1'b1;
      tick(2);
      chk({25'h0, tlim}, 32'h46);
      chk_bit(flag, 1'b0);
      @(posedge ref_clk_i) home <= 1'b1;
      tick(2);
      chk({25'h0, tlim}, 32'h64);
      @(posedge ref_clk_i) home <= 1'b0;
      @(posedge ref_clk_i) stop <= 1'b1;
      tick(2);
      chk({25'h0, tlim}, 32'h64);
      @(posedge ref_clk_i) stop <= 1'b0;
      @(posedge ref_clk_i) tq <= 7'h46;
      tick(3);
      chk_bit(flag, 1'b1);
      @(posedge ref_clk_i) pat1 <= 1'b1;
      @(posedge ref_clk_i) frec <= 1'b1;
      tick(1);
      chk(lag, 32'h0);
      chk_bit(flag, 1'b0);
      chk_bit(alarm, 1'b0);
      host.send(4, 1'b1, 1'b1);
      tick(4);
      chk(lag, 32'h4);
      chk_bit(flag, 1'b0);
      @(posedge ref_clk_i) tq <= 7'h00;
      @(posedge ref_clk_i) cap <= 1'b0;
      @(posedge ref_clk_i) frec <= 1'b0;
      @(posedge ref_clk_i) pat1 <= 1'b0;
      @(posedge ref_clk_i) frec <= 1'b1;
      tick(1);
      chk_bit(alarm, 1'b1);
      wr_reg(8'h00, 32'h1fff_1fff);
      rd_reg(8'h00);
      chk(d, 32'h1000_1000);
      // ratio 3/2, quadrature x4 under negative logic: 4 counts give 6 lag counts
      wr_reg(8'h00, 32'h0002_0003);
      wr_reg(8'h04, 32'h4);
      host.quad(2);
      tick(6);
      chk(lag, 32'h0000000a);
      @(posedge ref_clk_i) servo <= 1'b0;
      tick(1);
      chk_bit(flag, 1'b0);
      print_verdict();
   end
endmodule
`default_nettype wire

/* src/psg_gear.sv */
// Purpose: electronic gear, multiplier over divisor, as a residue accumulator
// Assumes: multiplier and divisor already within 1..4096
// Notes: emits at most one output count per clock; large ratios queue in the residue

`timescale 1ns/1ps
`default_nettype none

module psg_gear (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire logic cmd_step_i,
   input wire logic cmd_dir_i,
   input wire logic [12:0] mult_i,
   input wire logic [12:0] div_i,
   output logic step_o,
   output logic dir_o
);

   typedef struct packed {
      logic signed [25:0] residue;
      logic step;
      logic dir;
   } psg_gear_state_t;

   psg_gear_state_t s_reg;
   psg_gear_state_t s_next;
   logic signed [25:0] r;
   logic signed [25:0] m;
   logic signed [25:0] d;

   // -----------------------------------------------------------------
   // scale
   // -----------------------------------------------------------------
   always_comb begin
      m = $signed({13'h0, mult_i});
      d = $signed({13'h0, div_i});
      r = s_reg.residue;
      s_next = s_reg;
      s_next.step = 1'b0;
      if (cmd_step_i) begin
         r = cmd_dir_i ? 26'(r + m) : 26'(r - m); // [RULE13]
      end
      if (r >= d) begin
         r = 26'(r - d);
         s_next.step = 1'b1;
         s_next.dir = 1'b1;
      end else if (r <= -d) begin
         r = 26'(r + d);
         s_next.step = 1'b1;
         s_next.dir = 1'b0;
      end
      s_next.residue = r;
      if (clear_i) begin
         s_next = '0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign step_o = s_reg.step;
   assign dir_o = s_reg.dir;

endmodule

`default_nettype wire

/* src/psg_pkg.sv */
// Purpose: shared constants and helpers for the pulse servo status and gear block
// Assumes: 50 MHz reference clock, synchronous active-high reset
// Notes: all offsets, field positions, reset values and timing counts live here

package psg_pkg;

   // -----------------------------------------------------------------
   // register map (byte addresses, one aligned word each)
   // -----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_GEAR = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_WIDTH = 8'h08;
   localparam logic [7:0] ADDR_TORQUE = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_LAG = 8'h14;

   // -----------------------------------------------------------------
   // field layouts
   // -----------------------------------------------------------------
   localparam int GEAR_W = 13;
   localparam int GEAR_MULT_LSB = 0;
   localparam int GEAR_DIV_LSB = 16;
   localparam int MODE_FMT_LSB = 0;
   localparam int MODE_POL_BIT = 2;
   localparam int WIDTH_W = 16;
   localparam int PCT_W = 7;
   localparam int ST_SETTLED = 0;
   localparam int ST_CAP_ACTIVE = 1;
   localparam int ST_REACHED = 2;
   localparam int ST_SERVO = 3;
   localparam int ST_FLAG = 4;
   localparam int LAG_W = 32;
   localparam int RES_W = 26;
   localparam int QCNT_W = 16;

   // -----------------------------------------------------------------
   // reset values and limits
   // -----------------------------------------------------------------
   localparam logic [12:0] GEAR_MIN = 13'h0001;
   localparam logic [12:0] GEAR_MAX = 13'h1000;
   localparam logic [12:0] GEAR_MULT_RST = 13'h0800;
   localparam logic [12:0] GEAR_DIV_RST = 13'h007d;
   localparam logic [1:0] FMT_QUAD = 2'h0;
   localparam logic [1:0] FMT_PULSE_DIR = 2'h1;
   localparam logic [1:0] FMT_FWD_REV = 2'h2;
   localparam logic [1:0] FMT_RST = 2'h1;
   localparam logic POL_RST = 1'b0;
   localparam logic [15:0] WIDTH_RST = 16'h000a;
   localparam logic [6:0] TORQUE_MAX_PCT = 7'h46;
   localparam logic [6:0] TORQUE_RST = 7'h46;
   localparam logic [6:0] TORQUE_FULL_PCT = 7'h64;
   localparam int ENC_COUNTS_PER_REV = 800;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 50000000;
   localparam int QUIET_TIME_NS = 1000000;
   localparam int QUIET_CYCLES = (QUIET_TIME_NS / 1000) * (CLK_HZ / 1000000);

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // keeps a gear value inside 1..4096 so the divider never sees zero
   function automatic logic [12:0] clamp_gear(input logic [31:0] v);
      logic [12:0] r;
      r = v[12:0];
      if (v[31:0] == 32'h0000_0000) begin
         r = GEAR_MIN;
      end else if (v > {19'h0, GEAR_MAX}) begin
         r = GEAR_MAX;
      end
      return r;
   endfunction

   function automatic logic [31:0] abs_lag(input logic signed [31:0] v);
      return v[31] ? 32'(-v) : 32'(v);
   endfunction

endpackage

/* src/psg_pulse_decode.sv */
// Purpose: turns the two command pulse pins into one step and a direction
// Assumes: pins already synchronous to ref_clk_i
// Notes: an illegal format code produces no steps

`timescale 1ns/1ps
`default_nettype none

module psg_pulse_decode (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic pulse_input_a_i,
   input wire logic pulse_input_b_i,
   input wire logic [1:0] pulse_format_select_i,
   input wire logic polarity_i,
   output logic step_o,
   output logic dir_o
);

   typedef struct packed {
      logic a_prev;
      logic b_prev;
      logic step;
      logic dir;
   } psg_dec_state_t;

   psg_dec_state_t s_reg;
   psg_dec_state_t s_next;
   logic a;
   logic b;

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   always_comb begin
      a = pulse_input_a_i ^ polarity_i; // [RULE15] [RULE17]
      b = pulse_input_b_i ^ polarity_i;
      s_next = s_reg;
      s_next.a_prev = a;
      s_next.b_prev = b;
      s_next.step = 1'b0;
      s_next.dir = s_reg.dir;
      case (pulse_format_select_i) // [RULE15] [RULE16]
         psg_pkg::FMT_QUAD: begin
            // four-fold: every single-pin edge is a count; both at once is noise
            if ((a ^ s_reg.a_prev) ^ (b ^ s_reg.b_prev)) begin
               s_next.step = 1'b1;
               s_next.dir = ~(s_reg.a_prev ^ b);
            end
         end
         psg_pkg::FMT_PULSE_DIR: begin
            if (a && !s_reg.a_prev) begin
               s_next.step = 1'b1;
               s_next.dir = b;
            end
         end
         psg_pkg::FMT_FWD_REV: begin
            // simultaneous forward and reverse edges cancel
            if ((a && !s_reg.a_prev) != (b && !s_reg.b_prev)) begin
               s_next.step = 1'b1;
               s_next.dir = a && !s_reg.a_prev;
            end
         end
         default: begin
            s_next.step = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign step_o = s_reg.step;
   assign dir_o = s_reg.dir;

endmodule

`default_nettype wire

/* src/psg_top.sv */
// Purpose: deviation counter, position-settled report and thrust cap handling
// Assumes: encoder feedback arrives as a one-cycle step with a direction
// Notes: configuration sits behind a small register port
//
// Notes on behaviour
// (RULE1) servo on: settled output high when lag magnitude is within positioning width
// (RULE2) settled output stays low while the servo is off
// (RULE3) at servo-on present position is the target, so settled goes high
// (RULE4) any command pulse in the last 1ms forces settled low
// (RULE5) thrust cap request high limits torque to the programmed percentage
// (RULE6) with cap request high, settled output shows cap-reached instead
// (RULE7) cap request is ignored during home return or forced stop; the pattern 1 lag clear (clear_mode) still uses the raw request
// (RULE8) host must not drop cap request while cap-reached is high
// (RULE9) pattern 1 with cap request: fault recover input becomes lag clear
// (RULE10) a lag clear drops cap-reached and makes current position the target
// (RULE11) lag clear acts on its rising edge only; pulses still count meanwhile
// (RULE12) host asserts lag clear only when discarding lag is intended
// (RULE13) each command pulse is scaled by multiplier over divisor, 1..4096
// (RULE14) feedback is 800 encoder counts per revolution; gear sets unit travel
// (RULE15) pulse format and pin polarity come from configuration
// (RULE16) format 0 quadrature x4, 1 pulse plus sign, 2 forward/reverse
// (RULE17) polarity 0 positive logic, 1 negative logic
// (RULE18) lag adds scaled command steps and subtracts encoder feedback counts

`timescale 1ns/1ps
`default_nettype none

module psg_top #(
   parameter int unsigned QUIET_CYCLES = psg_pkg::QUIET_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire logic servo_on_i,
   input wire logic signal_pattern1_i,
   input wire logic home_return_active_i,
   input wire logic forced_stop_i,
   input wire logic pulse_input_a_i,
   input wire logic pulse_input_b_i,
   input wire logic thrust_cap_request_i,
   input wire logic fault_recover_input_i,
   input wire logic enc_step_i,
   input wire logic enc_dir_i,
   input wire logic [6:0] torque_now_pct_i,
   output logic position_settled_flag_o,
   output logic [6:0] torque_limit_pct_o,
   output logic alarm_reset_pulse_o,
   output logic [31:0] lag_count_o
);

   localparam logic [15:0] QUIET_MAX = 16'(QUIET_CYCLES);

   typedef struct packed {
      logic [12:0] mult;
      logic [12:0] div;
      logic [1:0] fmt;
      logic pol;
      logic [15:0] width;
      logic [6:0] torque;
      logic signed [31:0] lag;
      logic [15:0] quiet;
      logic servo_prev;
      logic res_prev;
      logic settled;
      logic reached;
      logic armed;
      logic flag;
      logic alarm_pulse;
      logic [6:0] tq_out;
      logic [31:0] rd_data;
   } psg_top_state_t;

   psg_top_state_t s_reg;
   psg_top_state_t s_next;

   logic cmd_step;
   logic cmd_dir;
   logic gear_step;
   logic gear_dir;
   logic cap_active;
   logic clear_mode;
   logic res_rise;
   logic lag_clear;
   logic gear_clear;
   logic signed [31:0] delta;
   logic [31:0] status;

   // -----------------------------------------------------------------
   // pulse front end and gear
   // -----------------------------------------------------------------
   psg_pulse_decode u_decode (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .pulse_input_a_i(pulse_input_a_i),
      .pulse_input_b_i(pulse_input_b_i),
      .pulse_format_select_i(s_reg.fmt),
      .polarity_i(s_reg.pol),
      .step_o(cmd_step),
      .dir_o(cmd_dir)
   );

   psg_gear u_gear (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .clear_i(gear_clear),
      .cmd_step_i(cmd_step),
      .cmd_dir_i(cmd_dir),
      .mult_i(s_reg.mult),
      .div_i(s_reg.div),
      .step_o(gear_step),
      .dir_o(gear_dir)
   );

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      cap_active = thrust_cap_request_i && !home_return_active_i && !forced_stop_i; // [RULE7]
      clear_mode = signal_pattern1_i && thrust_cap_request_i; // [RULE9]
      res_rise = fault_recover_input_i && !s_reg.res_prev; // [RULE11]
      lag_clear = clear_mode && res_rise && servo_on_i;
      gear_clear = lag_clear || !servo_on_i;
      // feedback counts are encoder counts, the unit the gear scales into
      delta = 32'sh0; // [RULE14]
      if (gear_step) begin
         delta = gear_dir ? 32'sh1 : -32'sh1;
      end
      if (enc_step_i) begin
         delta = enc_dir_i ? 32'(delta - 32'sh1) : 32'(delta + 32'sh1);
      end
      status = 32'h0;
      status[psg_pkg::ST_SETTLED] = s_reg.settled;
      status[psg_pkg::ST_CAP_ACTIVE] = cap_active;
      status[psg_pkg::ST_REACHED] = s_reg.reached;
      status[psg_pkg::ST_SERVO] = s_reg.servo_prev;
      status[psg_pkg::ST_FLAG] = s_reg.flag;

      s_next = s_reg;
      s_next.servo_prev = servo_on_i;
      s_next.res_prev = fault_recover_input_i;

      // lag count; held at zero while off so servo-on starts on target
      if (!servo_on_i || lag_clear) begin
         s_next.lag = 32'sh0; // [RULE3] [RULE10]
      end else begin
         s_next.lag = 32'(s_reg.lag + delta); // [RULE18] [RULE11]
      end

      // command quiet window; saturated while off so servo-on can report settled
      if (!servo_on_i) begin
         s_next.quiet = QUIET_MAX; // [RULE3]
      end else if (cmd_step) begin
         s_next.quiet = 16'h0; // [RULE4]
      end else if (s_reg.quiet < QUIET_MAX) begin
         s_next.quiet = 16'(s_reg.quiet + 16'h1);
      end

      s_next.settled = servo_on_i && (s_reg.quiet == QUIET_MAX) && // [RULE4]
         (psg_pkg::abs_lag(s_reg.lag) <= {16'h0, s_reg.width}); // [RULE1]

      // cap reached: re-armed only once torque falls under the limit after a clear,
      // so the clear really drops the flag while the load is still pressing
      if (lag_clear) begin
         s_next.armed = 1'b0; // [RULE10]
      end else if (torque_now_pct_i < s_reg.torque) begin
         s_next.armed = 1'b1;
      end
      if (!cap_active || !servo_on_i || lag_clear) begin
         s_next.reached = 1'b0; // [RULE10]
      end else if (s_reg.armed && torque_now_pct_i >= s_reg.torque) begin
         s_next.reached = 1'b1; // [RULE6]
      end

      // dropping the request while reached is a host fault; the cap is released anyway
      s_next.flag = servo_on_i && (cap_active ? s_next.reached : s_next.settled); // [RULE2] [RULE6] [RULE8]
      s_next.tq_out = cap_active ? s_reg.torque : psg_pkg::TORQUE_FULL_PCT; // [RULE5] [RULE7]
      s_next.alarm_pulse = res_rise && !clear_mode; // [RULE9]

      // register port
      s_next.rd_data = 32'h0;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            psg_pkg::ADDR_GEAR: begin
               s_next.rd_data[psg_pkg::GEAR_MULT_LSB +: psg_pkg::GEAR_W] = s_reg.mult;
               s_next.rd_data[psg_pkg::GEAR_DIV_LSB +: psg_pkg::GEAR_W] = s_reg.div;
            end
            psg_pkg::ADDR_MODE: begin
               s_next.rd_data[psg_pkg::MODE_FMT_LSB +: 2] = s_reg.fmt;
               s_next.rd_data[psg_pkg::MODE_POL_BIT] = s_reg.pol;
            end
            psg_pkg::ADDR_WIDTH: begin
               s_next.rd_data[psg_pkg::WIDTH_W-1:0] = s_reg.width;
            end
            psg_pkg::ADDR_TORQUE: begin
               s_next.rd_data[psg_pkg::PCT_W-1:0] = s_reg.torque;
            end
            psg_pkg::ADDR_STATUS: begin
               s_next.rd_data = status;
            end
            psg_pkg::ADDR_LAG: begin
               s_next.rd_data = s_reg.lag;
            end
            default: begin
               s_next.rd_data = 32'h0;
            end
         endcase
      end
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            psg_pkg::ADDR_GEAR: begin
               s_next.mult = psg_pkg::clamp_gear({19'h0, reg_wdata_i[12:0]}); // [RULE13]
               s_next.div = psg_pkg::clamp_gear({19'h0, reg_wdata_i[28:16]});
            end
            psg_pkg::ADDR_MODE: begin
               s_next.fmt = reg_wdata_i[psg_pkg::MODE_FMT_LSB +: 2]; // [RULE15]
               s_next.pol = reg_wdata_i[psg_pkg::MODE_POL_BIT];
            end
            psg_pkg::ADDR_WIDTH: begin
               s_next.width = reg_wdata_i[psg_pkg::WIDTH_W-1:0];
            end
            psg_pkg::ADDR_TORQUE: begin
               s_next.torque = (reg_wdata_i[6:0] > psg_pkg::TORQUE_MAX_PCT) ?
                  psg_pkg::TORQUE_MAX_PCT : reg_wdata_i[6:0];
            end
            default: begin
               s_next.torque = s_reg.torque;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.mult <= psg_pkg::GEAR_MULT_RST;
         s_reg.div <= psg_pkg::GEAR_DIV_RST;
         s_reg.fmt <= psg_pkg::FMT_RST; // [RULE16]
         s_reg.pol <= psg_pkg::POL_RST; // [RULE17]
         s_reg.width <= psg_pkg::WIDTH_RST;
         s_reg.torque <= psg_pkg::TORQUE_RST;
         s_reg.quiet <= QUIET_MAX;
         s_reg.armed <= 1'b1;
         s_reg.tq_out <= psg_pkg::TORQUE_FULL_PCT;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata_o = s_reg.rd_data;
   assign position_settled_flag_o = s_reg.flag;
   assign torque_limit_pct_o = s_reg.tq_out;
   assign alarm_reset_pulse_o = s_reg.alarm_pulse;
   assign lag_count_o = s_reg.lag;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   property p_servo_off_low;
      @(posedge ref_clk_i) disable iff (rst_i)
      !servo_on_i |=> !position_settled_flag_o;
   endproperty
   a_servo_off_low: assert property (p_servo_off_low) // [RULE2]
      else $error("settled output high with servo off");

   property p_servo_on_settles;
      @(posedge ref_clk_i) disable iff (rst_i)
      ($rose(servo_on_i) && !cap_active) |=> position_settled_flag_o;
   endproperty
   a_servo_on_settles: assert property (p_servo_on_settles) // [RULE3]
      else $error("settled output not high after servo on");

   property p_settled_in_width;
      @(posedge ref_clk_i) disable iff (rst_i)
      s_reg.settled |-> psg_pkg::abs_lag($past(s_reg.lag)) <= {16'h0, $past(s_reg.width)};
   endproperty
   a_settled_in_width: assert property (p_settled_in_width) // [RULE1]
      else $error("settled with lag outside positioning width");

   property p_pulse_blocks_settled;
      @(posedge ref_clk_i) disable iff (rst_i)
      cmd_step |-> ##2 !s_reg.settled;
   endproperty
   a_pulse_blocks_settled: assert property (p_pulse_blocks_settled) // [RULE4]
      else $error("settled despite recent command pulse");

   property p_cap_torque;
      @(posedge ref_clk_i) disable iff (rst_i)
      cap_active |=> torque_limit_pct_o == $past(s_reg.torque);
   endproperty
   a_cap_torque: assert property (p_cap_torque) // [RULE5]
      else $error("torque limit not applied under cap request");

   property p_cap_flag;
      @(posedge ref_clk_i) disable iff (rst_i)
      (servo_on_i && cap_active) |=> position_settled_flag_o == s_reg.reached;
   endproperty
   a_cap_flag: assert property (p_cap_flag) // [RULE6]
      else $error("output does not show cap reached");

   property p_cap_ignored;
      @(posedge ref_clk_i) disable iff (rst_i)
      (home_return_active_i || forced_stop_i) |=>
         (torque_limit_pct_o == psg_pkg::TORQUE_FULL_PCT) && !s_reg.reached;
   endproperty
   a_cap_ignored: assert property (p_cap_ignored) // [RULE7]
      else $error("cap request honoured during home return or stop");

   property p_clear_source;
      @(posedge ref_clk_i) disable iff (rst_i)
      lag_clear |-> signal_pattern1_i && thrust_cap_request_i && $rose(fault_recover_input_i);
   endproperty
   a_clear_source: assert property (p_clear_source) // [RULE9] [RULE11]
      else $error("lag clear without edge in pattern 1 under cap request");

   property p_clear_effect;
      @(posedge ref_clk_i) disable iff (rst_i)
      lag_clear |=> (s_reg.lag == 32'sh0) && !s_reg.reached && !position_settled_flag_o;
   endproperty
   a_clear_effect: assert property (p_clear_effect) // [RULE10]
      else $error("lag clear did not zero lag and drop cap reached");

   property p_lag_follows;
      @(posedge ref_clk_i) disable iff (rst_i)
      (servo_on_i && !lag_clear && gear_step && gear_dir && !enc_step_i) |=>
         s_reg.lag == 32'($past(s_reg.lag) + 32'sh1);
   endproperty
   a_lag_follows: assert property (p_lag_follows) // [RULE18]
      else $error("lag did not count a scaled command step");

endmodule

`default_nettype wire
